//--- hdl/scs_consts.svh
// Field positions, word limits, FIFO depth and timing constants of the SPI sequencer
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH
`define SCS_FMT_W         18
`define SCS_FMT_POL_BIT   17
`define SCS_FMT_PHA_BIT   16
`define SCS_FMT_PS_HI     15
`define SCS_FMT_PS_LO     8
`define SCS_FMT_LEN_HI    4
`define SCS_FMT_LEN_LO    0
`define SCS_DLY_W         16
`define SCS_DLY_C2T_HI    15
`define SCS_DLY_C2T_LO    8
`define SCS_DLY_T2C_HI    7
`define SCS_DLY_T2C_LO    0
`define SCS_WORD_MAX      5'd16
`define SCS_WORD_MIN      5'd2
`define SCS_SETUP_BASE    10'd2
`define SCS_TAIL_BASE     10'd1
`define SCS_PS0_PERIOD    9'd2
`define SCS_FIFO_DEPTH    8
`define SCS_GAP_MAX       11'h7ff
`endif

//--- hdl/scs_pkg.sv
// Types shared by the SPI sequencer modules
package scs_pkg;
  typedef struct packed {
    logic       polarity;
    logic       phase;
    logic [7:0] prescale;
    logic [4:0] length;
    logic [7:0] cs_to_clock_delay;
    logic [7:0] clock_to_cs_delay;
  } scs_cfg_s;
  typedef struct packed {
    logic        cs_hold_between_words;
    logic [15:0] data;
  } scs_word_s;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_SHIFT,
    ST_TAIL,
    ST_HOLD
  } scs_state_e;
endpackage

//--- hdl/scs_fifo.sv
// Transmit word FIFO, flip-flop storage
`timescale 1ns/1ns
module scs_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [CW-1:0]    count, next_count;
  logic             next_in_ready;
  logic             push, pop;

  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_comb begin
    push          = in_valid && in_ready;
    pop           = out_valid && out_ready;
    next_wr_ptr   = wr_ptr;
    next_rd_ptr   = rd_ptr;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
    end
    next_count    = CW'(count + CW'(push) - CW'(pop));
    // Registered ready so the top port comes from a flop
    next_in_ready = (next_count != CW'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
    end else begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      count    <= next_count;
      in_ready <= next_in_ready;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (push && wr_ptr == AW'(i)) begin
        mem[i] <= in_data;
      end
    end
  end

  a_fifo_full : assert property (@(posedge clk) disable iff (!rst_n)
    (count == CW'(DEPTH)) |-> !in_ready)
    else $error("fifo full but ready high");
endmodule

//--- hdl/scs_baud.sv
// Serial clock half-period timer
`timescale 1ns/1ns
`include "scs_consts.svh"
module scs_baud
  import scs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] prescale,
  input  wire logic       phase,
  input  wire logic       start,
  input  wire logic       run,
  output logic            edge_pulse,
  output logic [8:0]      half_a,
  output logic [8:0]      half_b
);
  logic [8:0] period;
  logic [8:0] remain, next_remain;
  logic       lead, next_lead;

  always_comb begin
    // Zero prescale still needs two cycles per period
    period      = (prescale == 8'h00) ? `SCS_PS0_PERIOD : 9'(prescale + 1'b1); // [R01] [R02]
    half_a      = {1'b0, period[8:1]}; // [R09]
    half_b      = 9'(period - half_a);
    edge_pulse  = run && (remain == 9'h000);
    next_remain = remain;
    next_lead   = lead;
    if (start) begin
      // Phase one delays the first edge by half a period
      next_remain = phase ? half_a : 9'h000; // [R06]
      next_lead   = 1'b1;
    end else if (edge_pulse) begin
      next_remain = 9'((lead ? half_b : half_a) - 1'b1);
      next_lead   = !lead;
    end else if (run) begin
      next_remain = 9'(remain - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remain <= 9'h000;
      lead   <= 1'b1;
    end else begin
      remain <= next_remain;
      lead   <= next_lead;
    end
  end

  a_half_sum : assert property (@(posedge clk) disable iff (!rst_n)
    (half_a + half_b == period) && (half_b - half_a <= 9'h001)) // [R09]
    else $error("half periods do not split the period");
endmodule

//--- hdl/scs_spi_ctrl.sv
// SPI controller sequencer: serial clock, chip select timing and shifting
// Behaviour
// R01: Prescale 1..255 gives a serial clock period of prescale plus one cycles.
// R02: Prescale zero gives a serial clock period of two cycles.
// R03: Polarity bit sets the idle level and thereby the active edge.
// R04: Controller select enables clock and data drivers; phase bit picks phase.
// R05: Phase zero: select to first edge is delay plus two, three with hold.
// R06: Phase one: adds half a period; extra cycle only idle-high with hold.
// R07: Phase zero: last edge to deselect is half period plus delay plus one.
// R08: Phase one: last edge to deselect is delay plus one cycle.
// R09: Serial clock high and low phases are each half the period; odd periods make the idle-level phase one cycle shorter.
// R10: Output bit changes half a period before the active sampling edge.
// R11: Both select delays come from the software delay fields.
// R12: Word length is programmable from 2 to 16 bits.
// R13: Sample input on active edge; keep select low between held words.
// R14: Peripheral drives its bit before the sampling edge while selected.
`timescale 1ns/1ns
`include "scs_consts.svh"
module scs_spi_ctrl
  import scs_pkg::*;
(
  input  wire logic                  CLK_SYS,
  input  wire logic                  RSTN,
  input  wire logic                  CONTROLLER_SELECT,
  input  wire logic [`SCS_FMT_W-1:0] WORD_FORMAT,
  input  wire logic [`SCS_DLY_W-1:0] CS_DELAY,
  input  wire logic                  TX_VALID,
  input  wire logic [15:0]           TX_DATA,
  input  wire logic                  TX_HOLD,
  output logic                       TX_READY,
  output logic                       RX_VALID,
  output logic [15:0]                RX_DATA,
  output logic                       BUSY,
  output logic                       SERIAL_CLOCK_LINE_O,
  output logic                       SERIAL_CLOCK_LINE_OE,
  output logic                       CONTROLLER_OUT_LINE_O,
  output logic                       CONTROLLER_OUT_LINE_OE,
  input  wire logic                  CONTROLLER_IN_LINE,
  output logic                       CHIP_SELECT_N
);
  scs_state_e state, next_state;
  scs_cfg_s   cfg, next_cfg, live_cfg;
  scs_word_s  word, next_word, fifo_word, tx_word;
  logic       fifo_valid, pop, do_load;
  logic [9:0] cnt, next_cnt, setup_tgt, tail_tgt;
  logic [5:0] ecount, next_ecount;
  logic [15:0] shreg, next_shreg, rx_shift, next_rx_shift, rx_mask;
  logic [15:0] next_rx_data;
  logic [4:0] len;
  logic       next_rx_valid, next_busy, next_oe, next_sclk, next_mosi, next_cs_n;
  logic       bstart, brun, bedge, leading, last_edge;
  logic [8:0] half_a, half_b;
  logic       in_s1, in_s2;

  assign tx_word = '{cs_hold_between_words: TX_HOLD, data: TX_DATA};

  scs_fifo #(
    .WIDTH ($bits(scs_word_s)),
    .DEPTH (`SCS_FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst_n     (RSTN),
    .in_valid  (TX_VALID),
    .in_data   (tx_word),
    .in_ready  (TX_READY),
    .out_valid (fifo_valid),
    .out_data  (fifo_word),
    .out_ready (pop)
  );

  assign brun = (state == ST_SHIFT);

  scs_baud u_baud (
    .clk        (CLK_SYS),
    .rst_n      (RSTN),
    .prescale   (cfg.prescale),
    .phase      (cfg.phase),
    .start      (bstart),
    .run        (brun),
    .edge_pulse (bedge),
    .half_a     (half_a),
    .half_b     (half_b)
  );

  function automatic logic [4:0] clamp_len(input logic [4:0] l);
    clamp_len = (l < `SCS_WORD_MIN) ? `SCS_WORD_MIN :
                (l > `SCS_WORD_MAX) ? `SCS_WORD_MAX : l;
  endfunction

  always_comb begin
    live_cfg.polarity          = WORD_FORMAT[`SCS_FMT_POL_BIT];
    live_cfg.phase             = WORD_FORMAT[`SCS_FMT_PHA_BIT];
    live_cfg.prescale          = WORD_FORMAT[`SCS_FMT_PS_HI:`SCS_FMT_PS_LO];
    live_cfg.length            = WORD_FORMAT[`SCS_FMT_LEN_HI:`SCS_FMT_LEN_LO];
    live_cfg.cs_to_clock_delay = CS_DELAY[`SCS_DLY_C2T_HI:`SCS_DLY_C2T_LO]; // [R11]
    live_cfg.clock_to_cs_delay = CS_DELAY[`SCS_DLY_T2C_HI:`SCS_DLY_T2C_LO]; // [R11]
    len       = clamp_len(cfg.length); // [R12]
    rx_mask   = 16'((17'h00001 << len) - 1'b1);
    // Extra setup cycle with hold: always in phase zero, idle-high only in phase one
    setup_tgt = `SCS_SETUP_BASE + 10'(cfg.cs_to_clock_delay)
              + 10'(word.cs_hold_between_words && (!cfg.phase || cfg.polarity)); // [R05] [R06]
    tail_tgt  = `SCS_TAIL_BASE + 10'(cfg.clock_to_cs_delay)
              + (cfg.phase ? 10'h000 : 10'(half_a)); // [R07] [R08]
    leading   = (SERIAL_CLOCK_LINE_O == cfg.polarity);
    last_edge = (ecount == 6'({len, 1'b0} - 1'b1));
    next_state    = state;
    next_cfg      = cfg;
    next_word     = word;
    next_cnt      = cnt;
    next_ecount   = ecount;
    next_shreg    = shreg;
    next_rx_shift = rx_shift;
    next_rx_data  = RX_DATA;
    next_rx_valid = 1'b0;
    next_sclk     = SERIAL_CLOCK_LINE_O;
    next_mosi     = CONTROLLER_OUT_LINE_O;
    next_cs_n     = CHIP_SELECT_N;
    next_oe       = CONTROLLER_SELECT; // [R04]
    do_load       = 1'b0;
    bstart        = 1'b0;
    case (state)
      ST_IDLE: begin
        next_sclk = live_cfg.polarity; // [R03]
        next_cs_n = 1'b1;
        if (CONTROLLER_SELECT && fifo_valid) begin // [R04]
          do_load    = 1'b1;
          next_cfg   = live_cfg;
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt == 10'(setup_tgt - 10'd2)) begin // [R05]
          bstart     = 1'b1;
          next_cnt   = 10'h000;
          next_state = ST_SHIFT;
        end else begin
          next_cnt = 10'(cnt + 1'b1);
        end
      end
      ST_SHIFT: begin
        if (bedge) begin
          next_sclk   = !SERIAL_CLOCK_LINE_O; // [R09]
          next_ecount = 6'(ecount + 1'b1);
          // Sample on the active edge, leading in phase zero
          if (leading != cfg.phase) begin
            next_rx_shift = {rx_shift[14:0], in_s2}; // [R13] [R14]
          end else begin
            // Output moves on the opposite edge, half a period early
            next_mosi  = shreg[15]; // [R10]
            next_shreg = {shreg[14:0], 1'b0};
          end
          if (last_edge) begin
            next_rx_data  = next_rx_shift & rx_mask; // [R12]
            next_rx_valid = 1'b1;
            next_cnt      = 10'h000;
            if (!word.cs_hold_between_words) begin
              next_state = ST_TAIL;
            end else if (fifo_valid && CONTROLLER_SELECT) begin
              do_load    = 1'b1; // [R13]
              next_state = ST_SETUP;
            end else begin
              next_state = ST_HOLD;
            end
          end
        end
      end
      ST_TAIL: begin
        if (cnt == 10'(tail_tgt - 1'b1)) begin // [R07] [R08]
          next_cs_n  = 1'b1;
          next_state = ST_IDLE;
        end else begin
          next_cnt = 10'(cnt + 1'b1);
        end
      end
      ST_HOLD: begin
        // Select stays low until the next word or controller mode ends
        if (!CONTROLLER_SELECT) begin
          next_cs_n  = 1'b1;
          next_state = ST_IDLE;
        end else if (fifo_valid) begin
          do_load    = 1'b1; // [R13]
          next_cnt   = 10'h000;
          next_state = ST_SETUP;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cs_n  = 1'b1;
      end
    endcase
    pop = do_load;
    if (do_load) begin
      next_word   = fifo_word;
      next_cs_n   = 1'b0;
      next_cnt    = 10'h000;
      next_ecount = 6'h00;
      next_shreg  = 16'(fifo_word.data << (`SCS_WORD_MAX - clamp_len(next_cfg.length)));
      if (!next_cfg.phase) begin
        // Phase zero presents the first bit before any edge
        next_mosi  = next_shreg[15]; // [R10]
        next_shreg = {next_shreg[14:0], 1'b0};
      end
    end
    next_busy = (next_state != ST_IDLE);
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      state                  <= ST_IDLE;
      cfg                    <= '0;
      word                   <= '0;
      cnt                    <= 10'h000;
      ecount                 <= 6'h00;
      shreg                  <= 16'h0000;
      rx_shift               <= 16'h0000;
      RX_DATA                <= 16'h0000;
      RX_VALID               <= 1'b0;
      BUSY                   <= 1'b0;
      SERIAL_CLOCK_LINE_O    <= 1'b0;
      SERIAL_CLOCK_LINE_OE   <= 1'b0;
      CONTROLLER_OUT_LINE_O  <= 1'b0;
      CONTROLLER_OUT_LINE_OE <= 1'b0;
      CHIP_SELECT_N          <= 1'b1;
      in_s1                  <= 1'b0;
      in_s2                  <= 1'b0;
    end else begin
      state                  <= next_state;
      cfg                    <= next_cfg;
      word                   <= next_word;
      cnt                    <= next_cnt;
      ecount                 <= next_ecount;
      shreg                  <= next_shreg;
      rx_shift               <= next_rx_shift;
      RX_DATA                <= next_rx_data;
      RX_VALID               <= next_rx_valid;
      BUSY                   <= next_busy;
      SERIAL_CLOCK_LINE_O    <= next_sclk;
      SERIAL_CLOCK_LINE_OE   <= next_oe;
      CONTROLLER_OUT_LINE_O  <= next_mosi;
      CONTROLLER_OUT_LINE_OE <= next_oe;
      CHIP_SELECT_N          <= next_cs_n;
      in_s1                  <= CONTROLLER_IN_LINE;
      in_s2                  <= in_s1;
    end
  end

  // Checking helpers: cycles since the last clock or select change
  logic        sclk_q, cs_q, fresh, firstp, next_fresh, next_firstp, sclk_chg, cs_chg;
  logic [10:0] gap, next_gap;
  logic [5:0]  hcnt, next_hcnt;
  logic [8:0]  exp_period;

  always_comb begin
    sclk_chg    = (SERIAL_CLOCK_LINE_O != sclk_q);
    cs_chg      = (CHIP_SELECT_N != cs_q);
    exp_period  = (cfg.prescale == 8'h00) ? 9'd2 : 9'(cfg.prescale + 1'b1);
    next_gap    = (sclk_chg || cs_chg) ? 11'h001 :
                  (gap == `SCS_GAP_MAX) ? gap : 11'(gap + 1'b1);
    next_fresh  = (cs_chg && !CHIP_SELECT_N) ? 1'b1 : sclk_chg ? 1'b0 : fresh;
    next_firstp = (state == ST_SETUP) ? 1'b1 : sclk_chg ? 1'b0 : firstp;
    next_hcnt   = (state == ST_SETUP) ? 6'h00 : sclk_chg ? 6'(hcnt + 1'b1) : hcnt;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
      gap    <= 11'h000;
      fresh  <= 1'b0;
      firstp <= 1'b0;
      hcnt   <= 6'h00;
    end else begin
      sclk_q <= SERIAL_CLOCK_LINE_O;
      cs_q   <= CHIP_SELECT_N;
      gap    <= next_gap;
      fresh  <= next_fresh;
      firstp <= next_firstp;
      hcnt   <= next_hcnt;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  // Idle level follows the live polarity, so only edges inside a frame count
  a_lead_period : assert property ( // [R01] [R02]
    (sclk_chg && !firstp && !CHIP_SELECT_N && SERIAL_CLOCK_LINE_O != cfg.polarity)
      |-> (gap == 11'(half_a)) && (half_a + half_b == exp_period))
    else $error("serial clock period wrong");
  a_trail_half : assert property ( // [R09]
    (sclk_chg && !firstp && !CHIP_SELECT_N && SERIAL_CLOCK_LINE_O == cfg.polarity)
      |-> gap == 11'(half_b))
    else $error("serial clock phase length wrong");
  a_idle_level : assert property ( // [R03]
    (state == ST_IDLE && CHIP_SELECT_N)
      |=> SERIAL_CLOCK_LINE_O == $past(WORD_FORMAT[`SCS_FMT_POL_BIT]))
    else $error("idle clock level wrong");
  a_drive_off : assert property ( // [R04]
    (!CONTROLLER_SELECT && state == ST_IDLE)
      |=> CHIP_SELECT_N && !SERIAL_CLOCK_LINE_OE && !CONTROLLER_OUT_LINE_OE && !BUSY)
    else $error("driving while not controller");
  a_setup_gap : assert property ( // [R05] [R06]
    (sclk_chg && fresh)
      |-> gap == 11'(setup_tgt) + (cfg.phase ? 11'(half_a) : 11'h000))
    else $error("select to clock delay wrong");
  a_tail_gap : assert property ( // [R07] [R08]
    (cs_chg && CHIP_SELECT_N && $past(state) == ST_TAIL) |-> gap == 11'(tail_tgt))
    else $error("clock to deselect delay wrong");
  a_out_stable : assert property ( // [R10]
    (sclk_chg && !CHIP_SELECT_N && ((SERIAL_CLOCK_LINE_O != cfg.polarity) != cfg.phase))
      |-> $stable(CONTROLLER_OUT_LINE_O))
    else $error("output changed on sampling edge");
  a_word_edges : assert property ( // [R12]
    RX_VALID |-> sclk_chg && hcnt == 6'({len, 1'b0} - 1'b1))
    else $error("edge count per word wrong");
  a_hold_select : assert property ( // [R13]
    (RX_VALID && word.cs_hold_between_words && CONTROLLER_SELECT)
      |-> !CHIP_SELECT_N ##1 !CHIP_SELECT_N)
    else $error("select dropped between held words");
endmodule

//--- dv/scs_periph.sv
// Behavioural SPI peripheral facing the sequencer's serial side
`timescale 1ns/1ns
module scs_periph (
  input  wire logic        clk,
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        mosi,
  input  wire logic        pol,
  input  wire logic        pha,
  input  wire logic [4:0]  len,
  input  wire logic [15:0] word,
  output logic             miso,
  output logic [15:0]      got
);
  int idx;
  task automatic shift_out();
    if (idx >= 0) miso = word[idx];
    idx = idx - 1;
  endtask
  initial begin
    miso = 1'b0;
    got = 16'h0000;
  end
  always @(negedge cs_n) begin
    idx = len - 1;
    got = 16'h0000;
    if (!pha) shift_out();
  end
  always @(sck) begin
    if (!cs_n && ((sck != pol) == !pha)) got = {got[14:0], mosi};
    else if (!cs_n) shift_out();
  end
  // Released line toggles so stale data never looks valid
  always @(negedge clk) if (cs_n) miso = ~miso;
endmodule

//--- dv/scs_spi_ctrl_tb.sv
// Self-checking bench for the SPI controller sequencer
`timescale 1ns/1ns
module scs_spi_ctrl_tb;
  logic        clk, rstn, sel, tv, th, miso, chk_iv, prev_cs, prev_sck, idle_lvl;
  logic [17:0] fmt;
  logic [15:0] dly, td, pw, got, rx_seen;
  logic        tx_ready, rx_valid, busy, sck_o, sck_oe, mo_o, mo_oe, cs_n;
  logic [15:0] rx_data;
  int          cyc, t_cs, t_first, t_last, t_rise, nedge, ncs, nrx, gap, last_gap;
  int          ep, eh1, fail_count, check_count;

  scs_spi_ctrl uut (
    .CLK_SYS(clk), .RSTN(rstn), .CONTROLLER_SELECT(sel), .WORD_FORMAT(fmt),
    .CS_DELAY(dly), .TX_VALID(tv), .TX_DATA(td), .TX_HOLD(th), .TX_READY(tx_ready),
    .RX_VALID(rx_valid), .RX_DATA(rx_data), .BUSY(busy), .SERIAL_CLOCK_LINE_O(sck_o),
    .SERIAL_CLOCK_LINE_OE(sck_oe), .CONTROLLER_OUT_LINE_O(mo_o),
    .CONTROLLER_OUT_LINE_OE(mo_oe), .CONTROLLER_IN_LINE(miso), .CHIP_SELECT_N(cs_n));

  // Undriven lines fall back to a pulled level
  scs_periph periph (
    .clk(clk), .cs_n(cs_n), .sck(sck_oe ? sck_o : fmt[17]), .mosi(mo_oe ? mo_o : 1'b1),
    .pol(fmt[17]), .pha(fmt[16]), .len(fmt[4:0]), .word(pw), .miso(miso), .got(got));

  always #5 clk = ~clk;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask

  always @(posedge clk) begin
    if (cyc > 50000) begin
      fail_count++;
      wrap_up();
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (rx_valid === 1'b1) begin
      rx_seen = rx_data;
      nrx++;
    end
    if (prev_cs && !cs_n) begin
      t_cs = cyc;
      nedge = 0;
      idle_lvl = sck_o;
    end
    if (!prev_cs && cs_n) begin
      t_rise = cyc;
      ncs++;
    end
    if (!cs_n && sck_o !== prev_sck) begin
      gap = cyc - t_last;
      if (nedge == 0) t_first = cyc;
      else if (chk_iv) begin
        chk("half", 1, gap == eh1 || gap == ep - eh1);
        if (nedge > 1) chk("period", ep, gap + last_gap);
      end
      last_gap = gap;
      t_last = cyc;
      nedge++;
    end
    prev_cs = cs_n;
    prev_sck = sck_o;
  end

  task automatic push(input logic [15:0] w, input logic h);
    @(posedge clk);
    tv <= 1'b1;
    td <= w;
    th <= h;
    @(posedge clk);
    while (!tx_ready) @(posedge clk);
    tv <= 1'b0;
  endtask

  task automatic idle_wait();
    repeat (4) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask

  task automatic one(input logic [17:0] f, input logic [15:0] d, input logic [15:0] w,
                     input logic [15:0] p);
    int          L;
    logic [31:0] m;
    L = f[4:0];
    ep = (f[15:8] == 0) ? 2 : f[15:8] + 1;
    eh1 = ep / 2;
    m = (32'h1 << L) - 1;
    chk_iv = 1'b1;
    fmt <= f;
    dly <= d;
    pw <= p;
    push(w, 1'b0);
    idle_wait();
    chk("edges", 2 * L, nedge);
    chk("setup", d[15:8] + 2 + (f[16] ? eh1 : 0), t_first - t_cs);
    chk("tail", d[7:0] + 1 + (f[16] ? 0 : eh1), t_rise - t_last);
    chk("idle", f[17], idle_lvl);
    chk("mosi", w & m, got);
    // Two-flop input path needs some margin before sampling
    if (f[15:8] >= 5 && d[15:8] >= 1) chk("rx", p & m, rx_seen);
  endtask

  initial begin
    int          L, c, n0;
    logic [15:0] a, b;
    logic [31:0] m;
    logic [7:0]  ps;
    clk = 1'b0;
    rstn = 1'b0;
    sel = 1'b0;
    fmt = 18'h00002;
    dly = 16'h0000;
    tv = 1'b0;
    td = 16'h0000;
    th = 1'b0;
    pw = 16'h0000;
    prev_cs = 1'b1;
    prev_sck = 1'b0;
    chk_iv = 1'b1;
    ep = 2;
    eh1 = 1;
    void'($urandom(32'h6f224ea5));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("sck_oe", 0, sck_oe);
    chk("mosi_oe", 0, mo_oe);
    n0 = nrx;
    for (int k = 0; k < 8; k++) push(16'($urandom), 1'b0);
    repeat (2) @(posedge clk);
    chk("ready_full", 0, tx_ready);
    tv <= 1'b1;
    @(posedge clk);
    tv <= 1'b0;
    repeat (20) @(posedge clk);
    chk("cs_idle", 1, cs_n);
    sel <= 1'b1;
    repeat (3) @(posedge clk);
    chk("busy", 1, busy);
    while (nrx - n0 < 8) @(posedge clk);
    idle_wait();
    chk("rx_count", 8, nrx - n0);
    chk("ready_empty", 1, tx_ready);
    chk("sck_oe", 1, sck_oe);
    chk("mosi_oe", 1, mo_oe);
    $display("test fifo and select done");
    for (int i = 0; i < 10; i++) begin
      ps = (i < 4) ? 8'((i == 3) ? 255 : i) : 8'(5 + $urandom % 16);
      L = (i == 0) ? 2 : (i == 1) ? 16 : 2 + $urandom % 15;
      one({2'($urandom), ps, 3'h0, 5'(L)}, {8'($urandom % 9), 8'($urandom % 9)},
          16'($urandom), 16'($urandom));
      $display("test random word %0d done", i);
    end
    for (int k = 0; k < 4; k++) begin
      L = 2 + $urandom % 7;
      c = $urandom % 6;
      a = 16'($urandom);
      b = 16'($urandom);
      m = (32'h1 << L) - 1;
      chk_iv = 1'b0;
      fmt <= {k[1:0], 8'h05, 3'h0, 5'(L)};
      dly <= {8'(c), 8'h02};
      n0 = ncs;
      push(a, 1'b1);
      push(b, 1'b0);
      idle_wait();
      chk("cs_rises", 1, ncs - n0);
      chk("edges", 4 * L, nedge);
      chk("setup", c + 2 + (k[0] ? 3 : 0) + ((!k[0] || k[1]) ? 1 : 0),
          t_first - t_cs);
      chk("mosi", ((a & m) << L) | (b & m), got);
      $display("test held pair %0d done", k);
    end
    // Lone held word: select stays low until controller mode is dropped
    fmt <= {2'b00, 8'h01, 3'h0, 5'd4};
    n0 = nrx;
    push(16'($urandom), 1'b1);
    while (nrx == n0) @(posedge clk);
    repeat (10) @(posedge clk);
    chk("cs_held", 0, cs_n);
    chk("busy_held", 1, busy);
    sel <= 1'b0;
    repeat (3) @(posedge clk);
    chk("cs_drop", 1, cs_n);
    chk("sck_oe_off", 0, sck_oe);
    sel <= 1'b1;
    repeat (2) @(posedge clk);
    $display("test hold and release done");
    wrap_up();
  end
endmodule
